/* include/ebc_defines.svh */
`ifndef EBC_DEFINES_SVH
`define EBC_DEFINES_SVH

// ****************************************************************
// Register numbers and operand limits.
// ****************************************************************
`define EBC_LINK_REG 4'he
`define EBC_TEST_REG_MAX 4'h7

// ****************************************************************
// Condition codes.
// ****************************************************************
`define EBC_COND_NEVER_FAILS 4'he

// ****************************************************************
// Rotate field codes.
// ****************************************************************
`define EBC_ROT_NONE 2'h0
`define EBC_ROT_8 2'h1
`define EBC_ROT_16 2'h2
`define EBC_ROT_24 2'h3

// ****************************************************************
// Address steps and branch reaches in bytes.
// ****************************************************************
`define EBC_STEP_NARROW 32'h0000_0002
`define EBC_STEP_WIDE 32'h0000_0004
`define EBC_REACH_FAR 32'sh0100_0000
`define EBC_REACH_NEAR 32'sh0010_0000
`define EBC_ZTEST_MIN 32'sh0000_0004
`define EBC_ZTEST_MAX 32'sh0000_0082

// ****************************************************************
// If-then block length.
// ****************************************************************
`define EBC_IT_MAX 3'h4

`endif

/* include/ebc_pkg.sv */
package ebc_pkg;

    // ****************************************************************
    // Operations presented by decode.
    // ****************************************************************
    typedef enum logic [3:0] {
        EBC_OP_NONE = 4'h0,
        EBC_OP_SIGN_EXTEND_BYTE = 4'h1,
        EBC_OP_ZERO_EXTEND_BYTE = 4'h2,
        EBC_OP_SIGN_EXTEND_HALF = 4'h3,
        EBC_OP_ZERO_EXTEND_HALF = 4'h4,
        EBC_OP_JUMP_DIRECT = 4'h5,
        EBC_OP_CONDITIONAL_JUMP = 4'h6,
        EBC_OP_CALL_DIRECT = 4'h7,
        EBC_OP_JUMP_REGISTER = 4'h8,
        EBC_OP_CALL_REGISTER = 4'h9,
        EBC_OP_ZERO_TEST_BRANCH = 4'ha,
        EBC_OP_NONZERO_TEST_BRANCH = 4'hb,
        EBC_OP_IF_THEN_PREFIX = 4'hc,
        EBC_OP_BREAKPOINT = 4'hd,
        EBC_OP_OTHER = 4'he
    } ebc_op_t;

endpackage

/* rtl/ebc_exec.sv */
`timescale 1ns/100ps
`include "ebc_defines.svh"

module ebc_exec
    import ebc_pkg::*;
#(
    parameter int DATA_W = 32,
    parameter int IT_LEN = 4
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire ebc_op_t instr_op,
    input wire logic [31:0] instr_pc,
    input wire logic instr_wide,
    input wire logic [3:0] instr_cond,
    input wire logic instr_sets_flags,
    input wire logic [3:0] dest_index,
    input wire logic [3:0] src_index,
    input wire logic [31:0] src_value,
    input wire logic [1:0] rotate_option,
    input wire logic [31:0] imm_offset,
    input wire logic [1:0] it_extra,
    input wire logic [2:0] it_switch_else,
    input wire logic [3:0] flags_nzcv,
    output logic wb_en_q,
    output logic [3:0] wb_index_q,
    output logic [31:0] wb_data_q,
    output logic flags_we_q,
    output logic pass_q,
    output logic redirect_q,
    output logic [31:0] redirect_addr_q,
    output logic flush_q,
    output logic bad_usage_trap_q,
    output logic breakpoint_q,
    output logic illegal_q,
    output logic it_active_q
);

    // ****************************************************************
    // Elaboration checks.
    // ****************************************************************
    if (DATA_W != 32) begin : g_bad_width
        $error("ebc_exec serves only a 32-bit data path.");
    end
    if (IT_LEN != 4) begin : g_bad_it
        $error("ebc_exec serves only four-slot if-then blocks.");
    end

    // ****************************************************************
    // Condition evaluation.
    // ****************************************************************
    function automatic logic ebc_cond(input logic [3:0] cond, input logic [3:0] f);
        logic r;
        r = 1'b1;
        unique case (cond[3:1])
            3'h0: r = f[2];
            3'h1: r = f[1];
            3'h2: r = f[3];
            3'h3: r = f[0];
            3'h4: r = f[1] & ~f[2];
            3'h5: r = (f[3] == f[0]);
            3'h6: r = ~f[2] & (f[3] == f[0]);
            3'h7: r = 1'b1;
        endcase
        // Odd codes invert their even partner, except the always pair.
        return r ^ (cond[0] & (cond[3:1] != 3'h7));
    endfunction

    // ****************************************************************
    // Extend datapath.
    // ****************************************************************
    logic [31:0] rotated;
    logic [31:0] extended;

    always_comb
    begin
        unique case (rotate_option)
            `EBC_ROT_NONE: rotated = src_value;
            `EBC_ROT_8: rotated = {src_value[7:0], src_value[31:8]};
            `EBC_ROT_16: rotated = {src_value[15:0], src_value[31:16]};
            `EBC_ROT_24: rotated = {src_value[23:0], src_value[31:24]};
        endcase
        unique case (instr_op)
            EBC_OP_SIGN_EXTEND_BYTE: extended = {{24{rotated[7]}}, rotated[7:0]};
            EBC_OP_ZERO_EXTEND_BYTE: extended = {24'h00_0000, rotated[7:0]};
            EBC_OP_SIGN_EXTEND_HALF: extended = {{16{rotated[15]}}, rotated[15:0]};
            default: extended = {16'h0000, rotated[15:0]};
        endcase
    end

    // ****************************************************************
    // If-then state and execute results.
    // ****************************************************************
    logic [2:0] it_cnt_q;
    logic [2:0] it_cnt_d;
    logic [3:0] it_base_q;
    logic [3:0] it_base_d;
    logic [3:0] it_inv_q;
    logic [3:0] it_inv_d;
    logic wb_en_d;
    logic [3:0] wb_index_d;
    logic [31:0] wb_data_d;
    logic flags_we_d;
    logic pass_d;
    logic redirect_d;
    logic [31:0] redirect_addr_d;
    logic bad_usage_trap_d;
    logic breakpoint_d;
    logic illegal_d;
    logic in_it;
    logic pass;
    logic [31:0] next_addr;
    logic [31:0] imm_target;
    logic signed [31:0] off;
    logic far_ok;
    logic near_ok;

    always_comb
    begin
        it_cnt_d = it_cnt_q;
        it_base_d = it_base_q;
        it_inv_d = it_inv_q;
        wb_en_d = 1'b0;
        wb_index_d = wb_index_q;
        wb_data_d = wb_data_q;
        flags_we_d = 1'b0;
        pass_d = 1'b0;
        redirect_d = 1'b0;
        redirect_addr_d = redirect_addr_q;
        bad_usage_trap_d = 1'b0;
        breakpoint_d = 1'b0;
        illegal_d = 1'b0;
        in_it = (it_cnt_q != 3'h0);
        off = imm_offset;
        far_ok = (off >= -`EBC_REACH_FAR) && (off < `EBC_REACH_FAR);
        near_ok = (off >= -`EBC_REACH_NEAR) && (off < `EBC_REACH_NEAR);
        next_addr = instr_pc + (instr_wide ? `EBC_STEP_WIDE : `EBC_STEP_NARROW);
        imm_target = instr_pc + imm_offset;
        // Flags are sampled live so a flag update earlier in the block is seen.
        if (in_it)
        begin
            if (it_base_q == `EBC_COND_NEVER_FAILS)
            begin
                pass = 1'b1;
            end
            else
            begin
                pass = ebc_cond(it_base_q, flags_nzcv) ^ it_inv_q[0];
            end
        end
        else if (instr_op == EBC_OP_CONDITIONAL_JUMP)
        begin
            pass = ebc_cond(instr_cond, flags_nzcv);
        end
        else
        begin
            pass = 1'b1;
        end
        if (instr_valid && (instr_op != EBC_OP_NONE))
        begin
            pass_d = pass;
            if (in_it)
            begin
                it_cnt_d = it_cnt_q - 3'h1;
                it_inv_d = {1'b0, it_inv_q[3:1]};
            end
            unique case (instr_op)
                EBC_OP_SIGN_EXTEND_BYTE, EBC_OP_ZERO_EXTEND_BYTE, EBC_OP_SIGN_EXTEND_HALF,
                EBC_OP_ZERO_EXTEND_HALF:
                begin
                    wb_en_d = pass;
                    wb_index_d = dest_index;
                    wb_data_d = extended;
                end
                EBC_OP_JUMP_DIRECT, EBC_OP_CALL_DIRECT:
                begin
                    if (!far_ok)
                    begin
                        illegal_d = 1'b1;
                    end
                    else if (pass)
                    begin
                        redirect_d = 1'b1;
                        redirect_addr_d = imm_target;
                        if (instr_op == EBC_OP_CALL_DIRECT)
                        begin
                            wb_en_d = 1'b1;
                            wb_index_d = `EBC_LINK_REG;
                            wb_data_d = next_addr | 32'h0000_0001;
                        end
                    end
                end
                EBC_OP_CONDITIONAL_JUMP:
                begin
                    if (in_it ? !far_ok : !near_ok)
                    begin
                        illegal_d = 1'b1;
                    end
                    else if (pass)
                    begin
                        redirect_d = 1'b1;
                        redirect_addr_d = imm_target;
                    end
                end
                EBC_OP_JUMP_REGISTER, EBC_OP_CALL_REGISTER:
                begin
                    if (pass)
                    begin
                        if (!src_value[0])
                        begin
                            bad_usage_trap_d = 1'b1;
                        end
                        else
                        begin
                            redirect_d = 1'b1;
                            redirect_addr_d = {src_value[31:1], 1'b0};
                            if (instr_op == EBC_OP_CALL_REGISTER)
                            begin
                                wb_en_d = 1'b1;
                                wb_index_d = `EBC_LINK_REG;
                                wb_data_d = next_addr | 32'h0000_0001;
                            end
                        end
                    end
                end
                EBC_OP_ZERO_TEST_BRANCH, EBC_OP_NONZERO_TEST_BRANCH:
                begin
                    // Inside a block these are refused rather than guessed at.
                    if (in_it || (src_index > `EBC_TEST_REG_MAX) || (off < `EBC_ZTEST_MIN) ||
                        (off > `EBC_ZTEST_MAX))
                    begin
                        illegal_d = 1'b1;
                        pass_d = 1'b0;
                    end
                    else if ((src_value == 32'h0000_0000) == (instr_op == EBC_OP_ZERO_TEST_BRANCH))
                    begin
                        redirect_d = 1'b1;
                        redirect_addr_d = imm_target;
                    end
                end
                EBC_OP_IF_THEN_PREFIX:
                begin
                    if (in_it)
                    begin
                        illegal_d = 1'b1;
                        pass_d = 1'b0;
                    end
                    else
                    begin
                        it_cnt_d = {1'b0, it_extra} + 3'h1;
                        it_base_d = instr_cond;
                        it_inv_d = (instr_cond == `EBC_COND_NEVER_FAILS) ? 4'h0 :
                            {it_switch_else, 1'b0};
                    end
                end
                EBC_OP_BREAKPOINT:
                begin
                    breakpoint_d = 1'b1;
                    pass_d = 1'b1;
                end
                default:
                begin
                    flags_we_d = pass & instr_sets_flags;
                end
            endcase
            // A taken branch leaves the block, so no slot outlives it.
            if (redirect_d || bad_usage_trap_d)
            begin
                it_cnt_d = 3'h0;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            it_cnt_q <= 3'h0;
            it_base_q <= 4'h0;
            it_inv_q <= 4'h0;
            wb_en_q <= 1'b0;
            wb_index_q <= 4'h0;
            wb_data_q <= 32'h0000_0000;
            flags_we_q <= 1'b0;
            pass_q <= 1'b0;
            redirect_q <= 1'b0;
            redirect_addr_q <= 32'h0000_0000;
            flush_q <= 1'b0;
            bad_usage_trap_q <= 1'b0;
            breakpoint_q <= 1'b0;
            illegal_q <= 1'b0;
            it_active_q <= 1'b0;
        end
        else
        begin
            it_cnt_q <= it_cnt_d;
            it_base_q <= it_base_d;
            it_inv_q <= it_inv_d;
            wb_en_q <= wb_en_d;
            wb_index_q <= wb_index_d;
            wb_data_q <= wb_data_d;
            flags_we_q <= flags_we_d;
            pass_q <= pass_d;
            redirect_q <= redirect_d;
            redirect_addr_q <= redirect_addr_d;
            flush_q <= redirect_d;
            bad_usage_trap_q <= bad_usage_trap_d;
            breakpoint_q <= breakpoint_d;
            illegal_q <= illegal_d;
            it_active_q <= (it_cnt_d != 3'h0);
        end
    end

endmodule // ebc_exec

/* test/ebc_exec_monitor.sv */
`timescale 1ns/100ps
// ****
// Port checker for the execution unit.
// ****
module ebc_exec_monitor
    import ebc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire ebc_op_t instr_op,
    input wire logic [31:0] instr_pc,
    input wire logic instr_wide,
    input wire logic [3:0] src_index,
    input wire logic [31:0] src_value,
    input wire logic [1:0] rotate_option,
    input wire logic [31:0] imm_offset,
    input wire logic [1:0] it_extra,
    input wire logic wb_en_q,
    input wire logic [3:0] wb_index_q,
    input wire logic [31:0] wb_data_q,
    input wire logic flags_we_q,
    input wire logic pass_q,
    input wire logic redirect_q,
    input wire logic flush_q,
    input wire logic bad_usage_trap_q,
    input wire logic breakpoint_q,
    input wire logic illegal_q,
    input wire logic it_active_q
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Block checks only look outside a block, where the block condition cannot mask them.
    sequence s_prefix_one;
        instr_valid && instr_op == EBC_OP_IF_THEN_PREFIX && !it_active_q && it_extra == 2'h0;
    endsequence
    sequence s_slot;
        instr_valid && instr_op != EBC_OP_NONE;
    endsequence
    property p_flags;
        !(instr_valid && instr_op == EBC_OP_OTHER) |=> !flags_we_q;
    endproperty
    a_flags: assert property (p_flags) else $error("flags written by a modelled op");
    property p_flush;
        flush_q == redirect_q;
    endproperty
    a_flush: assert property (p_flush) else $error("flush and redirect differ");
    property p_link;
        instr_valid && instr_op == EBC_OP_CALL_DIRECT && !it_active_q |=> !redirect_q || (wb_en_q &&
            wb_index_q == 4'he && wb_data_q == (($past(instr_pc) + ($past(instr_wide) ? 32'h4 : 32'h2)) | 32'h1));
    endproperty
    a_link: assert property (p_link) else $error("call link value wrong");
    property p_trap;
        instr_valid && instr_op == EBC_OP_JUMP_REGISTER && !it_active_q && !src_value[0]
            |=> bad_usage_trap_q && !redirect_q && !wb_en_q;
    endproperty
    a_trap: assert property (p_trap) else $error("even register target not trapped");
    property p_ztest;
        instr_valid && instr_op == EBC_OP_ZERO_TEST_BRANCH && !it_active_q && src_index < 4'h8 &&
            $signed(imm_offset) >= 4 && $signed(imm_offset) <= 130 |=> redirect_q == ($past(src_value) == 32'h0);
    endproperty
    a_ztest: assert property (p_ztest) else $error("zero test branch decision wrong");
    property p_zreg;
        instr_valid && instr_op == EBC_OP_ZERO_TEST_BRANCH && src_index > 4'h7 |=> illegal_q && !redirect_q;
    endproperty
    a_zreg: assert property (p_zreg) else $error("high tested register accepted");
    property p_reach;
        instr_valid && instr_op == EBC_OP_CONDITIONAL_JUMP && !it_active_q && $signed(imm_offset) >= 32'sh0010_0000
            |=> illegal_q && !redirect_q;
    endproperty
    a_reach: assert property (p_reach) else $error("near reach exceeded");
    property p_it_open;
        s_prefix_one |=> it_active_q;
    endproperty
    a_it_open: assert property (p_it_open) else $error("block did not open");
    property p_it_close;
        s_prefix_one ##1 s_slot |=> !it_active_q;
    endproperty
    a_it_close: assert property (p_it_close) else $error("one slot block did not close");
    property p_breakpoint_op;
        instr_valid && instr_op == EBC_OP_BREAKPOINT |=> breakpoint_q && pass_q;
    endproperty
    a_breakpoint_op: assert property (p_breakpoint_op) else $error("breakpoint not executed");
    property p_half_rot;
        instr_valid && instr_op == EBC_OP_SIGN_EXTEND_HALF && rotate_option == 2'h2 && !it_active_q
            |=> wb_en_q && wb_data_q == {{16{$past(src_value[31])}}, $past(src_value[31:16])};
    endproperty
    a_half_rot: assert property (p_half_rot) else $error("rotated half extend wrong");
endmodule // ebc_exec_monitor

bind ebc_exec ebc_exec_monitor mon (.sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_pc(instr_pc), .instr_wide(instr_wide), .src_index(src_index), .src_value(src_value),
    .rotate_option(rotate_option), .imm_offset(imm_offset), .it_extra(it_extra), .wb_en_q(wb_en_q),
    .wb_index_q(wb_index_q), .wb_data_q(wb_data_q), .flags_we_q(flags_we_q), .pass_q(pass_q),
    .redirect_q(redirect_q), .flush_q(flush_q), .bad_usage_trap_q(bad_usage_trap_q),
    .breakpoint_q(breakpoint_q), .illegal_q(illegal_q), .it_active_q(it_active_q));

/* test/tb.sv */
`timescale 1ns/100ps
`define CHECK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module tb
    import ebc_pkg::*;
;
    // ****
    // Stimulus and result scoreboard.
    // ****
    typedef struct {string n; logic [73:0] v;} ebc_note_t;
    logic sys_clk, rst, instr_valid, instr_wide, instr_sets_flags;
    ebc_op_t instr_op;
    logic [31:0] instr_pc, src_value, imm_offset, x, y, d;
    logic [3:0] instr_cond, dest_index, src_index, flags_nzcv, wb_index_q, ix, jx;
    logic [1:0] rotate_option, it_extra;
    logic [2:0] it_switch_else;
    logic wb_en_q, flags_we_q, pass_q, redirect_q, flush_q, bad_usage_trap_q, breakpoint_q, illegal_q, it_active_q;
    logic [31:0] wb_data_q, redirect_addr_q;
    int bad_count = 0;
    int tests_run = 0;
    ebc_note_t q[$];
    ebc_note_t nt;
    // Data fields are masked by their strobes, since held values carry no meaning.
    wire logic [73:0] got = {wb_en_q, wb_en_q ? wb_index_q : 4'h0, wb_en_q ? wb_data_q : 32'h0, redirect_q,
        redirect_q ? redirect_addr_q : 32'h0, bad_usage_trap_q, illegal_q, breakpoint_q, flags_we_q};

    ebc_exec uut (.sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid), .instr_op(instr_op), .instr_pc(instr_pc),
        .instr_wide(instr_wide), .instr_cond(instr_cond), .instr_sets_flags(instr_sets_flags),
        .dest_index(dest_index), .src_index(src_index), .src_value(src_value), .rotate_option(rotate_option),
        .imm_offset(imm_offset), .it_extra(it_extra), .it_switch_else(it_switch_else), .flags_nzcv(flags_nzcv),
        .wb_en_q(wb_en_q), .wb_index_q(wb_index_q), .wb_data_q(wb_data_q), .flags_we_q(flags_we_q),
        .pass_q(pass_q), .redirect_q(redirect_q), .redirect_addr_q(redirect_addr_q), .flush_q(flush_q),
        .bad_usage_trap_q(bad_usage_trap_q), .breakpoint_q(breakpoint_q), .illegal_q(illegal_q),
        .it_active_q(it_active_q));

    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    function automatic logic [73:0] mk(logic wb = 0, logic [3:0] idx = 0, logic [31:0] dv = 0, logic rd = 0,
        logic [31:0] a = 0, logic [3:0] ev = 0);
        return {wb, idx, dv, rd, a, ev};
    endfunction

    task automatic note(string n, logic [73:0] v);
        q.push_back('{n, v});
    endtask

    task automatic issue(ebc_op_t op, logic [31:0] v = 0, logic [31:0] off = 0, logic w = 0, logic [3:0] c = 4'he,
        logic [3:0] f = 0, logic [3:0] ri = 0, logic [1:0] ro = 0, logic [1:0] ex = 0, logic [2:0] sw = 0,
        logic [3:0] di = 0, logic sf = 1);
        instr_valid = 1'b1;
        instr_op = op;
        src_value = v;
        imm_offset = off;
        instr_wide = w;
        instr_cond = c;
        flags_nzcv = f;
        src_index = ri;
        dest_index = di;
        instr_sets_flags = sf;
        rotate_option = ro;
        it_extra = ex;
        it_switch_else = sw;
        @(negedge sys_clk);
        // Addresses advance as in straight-line code.
        instr_pc = instr_pc + (w ? 32'h0000_0004 : 32'h0000_0002);
    endtask

    task automatic end_of_test();
        if (bad_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(negedge sys_clk)
    begin
        if (!rst && (wb_en_q | redirect_q | bad_usage_trap_q | illegal_q | breakpoint_q | flags_we_q))
        begin
            if (q.size() == 0)
                `CHECK("unexpected", 74'h0, got)
            else
            begin
                nt = q.pop_front();
                `CHECK(nt.n, nt.v, got)
                `CHECK("flush", nt.v[36], flush_q)
            end
        end
    end

    initial
    begin
        #50000;
        bad_count++;
        $display("BAD watchdog exp %h got %h", 1'b0, 1'b1);
        end_of_test();
    end

    initial
    begin
        rst = 1'b1;
        instr_valid = 1'b0;
        instr_op = EBC_OP_NONE;
        instr_sets_flags = 1'b1;
        {instr_wide, instr_cond, dest_index, src_index, src_value, rotate_option} = '0;
        {imm_offset, it_extra, it_switch_else, flags_nzcv} = '0;
        void'($urandom(33));
        instr_pc = $urandom() & 32'hffff_fffe;
        repeat (8) @(negedge sys_clk);
        rst = 1'b0;
        for (int o = 0; o < 4; o++)
            for (int r = 0; r < 4; r++)
            begin
                x = $urandom();
                ix = 4'($urandom_range(12));
                jx = 4'($urandom_range(12));
                y = (x >> (8 * r)) | (x << (32 - 8 * r));
                d = o == 0 ? {{24{y[7]}}, y[7:0]} : o == 1 ? {24'h0, y[7:0]} :
                    o == 2 ? {{16{y[15]}}, y[15:0]} : {16'h0, y[15:0]};
                note("extend", mk(.wb(1), .idx(jx), .dv(d)));
                issue(ebc_op_t'(4'(o + 1)), .v(x), .ri(ix), .ro(2'(r)), .di(jx));
            end
        note("call", mk(1, 4'he, instr_pc + 32'h5, 1, instr_pc + 32'h00ff_fffe));
        issue(EBC_OP_CALL_DIRECT, .off(32'h00ff_fffe), .w(1'b1));
        note("call_far", mk(.ev(4'h4)));
        issue(EBC_OP_CALL_DIRECT, .off(32'h0100_0000));
        note("bcond_near", mk(.rd(1), .a(instr_pc + 32'hfff0_0000)));
        issue(EBC_OP_CONDITIONAL_JUMP, .off(32'hfff0_0000), .c(4'h0), .f(4'h4));
        note("bcond_out", mk(.ev(4'h4)));
        issue(EBC_OP_CONDITIONAL_JUMP, .off(32'h0010_0000), .c(4'h0), .f(4'h4));
        note("jreg", mk(.rd(1), .a(32'h2000)));
        issue(EBC_OP_JUMP_REGISTER, .v(32'h2001));
        note("jreg_trap", mk(.ev(4'h8)));
        issue(EBC_OP_JUMP_REGISTER, .v(32'h2000));
        note("creg", mk(1, 4'he, instr_pc + 32'h3, 1, 32'h3000));
        issue(EBC_OP_CALL_REGISTER, .v(32'h3001));
        note("creg_trap", mk(.ev(4'h8)));
        issue(EBC_OP_CALL_REGISTER, .v(32'h3000));
        note("ztest", mk(.rd(1), .a(instr_pc + 32'h4)));
        issue(EBC_OP_ZERO_TEST_BRANCH, .ri(4'h3), .off(32'h4));
        issue(EBC_OP_ZERO_TEST_BRANCH, .ri(4'h3), .v(32'h5), .off(32'h4));
        note("nztest", mk(.rd(1), .a(instr_pc + 32'h82)));
        issue(EBC_OP_NONZERO_TEST_BRANCH, .ri(4'h7), .v(32'h5), .off(32'h82));
        for (int k = 0; k < 3; k++)
        begin
            note("ztest_bad", mk(.ev(4'h4)));
            issue(EBC_OP_ZERO_TEST_BRANCH, .ri(k == 0 ? 4'h8 : 4'h3), .off(k == 2 ? 32'h2 : k == 1 ? 32'h84 : 32'h4));
        end
        // The zero flag drops in the last slot so a stale snapshot of the flags would pass it.
        issue(EBC_OP_IF_THEN_PREFIX, .c(4'h0), .ex(2'h3), .sw(3'b010));
        for (int k = 0; k < 4; k++)
        begin
            if (k < 2)
                note("it_slot", mk(.ev(4'h1)));
            issue(EBC_OP_OTHER, .f(k == 3 ? 4'h0 : 4'h4));
        end
        note("after_block", mk(.ev(4'h1)));
        issue(EBC_OP_OTHER);
        issue(EBC_OP_OTHER, .sf(1'b0));
        // A reset inside an open block must drop the slots still pending.
        issue(EBC_OP_IF_THEN_PREFIX, .c(4'h0), .ex(2'h3));
        rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        note("after_reset", mk(.ev(4'h1)));
        issue(EBC_OP_OTHER);
        issue(EBC_OP_IF_THEN_PREFIX, .c(4'he), .ex(2'h1));
        for (int k = 0; k < 2; k++)
        begin
            note("always_slot", mk(.ev(4'h1)));
            issue(EBC_OP_OTHER, .f(4'(k * 4)));
        end
        issue(EBC_OP_IF_THEN_PREFIX, .c(4'h0));
        note("breakpoint_op", mk(.ev(4'h2)));
        issue(EBC_OP_BREAKPOINT);
        issue(EBC_OP_IF_THEN_PREFIX, .c(4'h1), .ex(2'h1));
        note("it_first", mk(.ev(4'h1)));
        issue(EBC_OP_OTHER);
        note("bcond_far", mk(.rd(1), .a(instr_pc + 32'h00ff_fffe)));
        issue(EBC_OP_CONDITIONAL_JUMP, .off(32'h00ff_fffe));
        instr_valid = 1'b0;
        for (int k = 0; k < 20 && q.size() > 0; k++)
            @(negedge sys_clk);
        `CHECK("pending", 32'h0, 32'(q.size()))
        end_of_test();
    end
endmodule // tb
